// *** rtl/host_reset_edge.sv ***
// Rising edge detector for the host bus reset, one-cycle pulse on release
`timescale 1ns/1ps
module host_reset_edge (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Level in, pulse out
   input wire logic host_reset_n,
   output logic release_pulse
);
   logic prev_r;

   // Reset to the pin's idle level, or leaving reset looks like a release
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         prev_r <= 1'b1;
      end else begin
         prev_r <= host_reset_n;
      end
   end

   assign release_pulse = host_reset_n & ~prev_r;
endmodule

// *** rtl/wake_control.sv ***
// Wake-up control register bank with shared PME bits, filter allocation and wake pin
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module wake_control (
   // Clock and resets
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic por_n,
   input wire logic host_reset_n,
   input wire logic d3cold_supported,
   // Nonvolatile memory load values
   input wire logic nvm_apm_wake_enable,
   input wire logic nvm_link_change_wake_override,
   // Register port
   input wire logic [15:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Configuration space PME access
   input wire logic cfg_pme_en_wr,
   input wire logic cfg_pme_en_wdata,
   input wire logic cfg_pme_status_clr,
   output logic pme_en,
   output logic pme_status,
   // Wake events from the receive filters
   input wire logic magic_match,
   input wire logic link_change,
   input wire logic flex0_match,
   input wire logic flex1_match,
   input wire logic other_wake_event,
   // Filter routing
   output logic flex0_to_manageability,
   output logic flex1_to_manageability,
   // Platform side
   output logic wake_pin_n,
   output logic irq
);
   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   logic apm_wake_enable_r;
   logic pme_en_r;
   logic pme_status_r;
   logic apm_assert_pme_r;
   logic link_change_wake_enable_r;
   logic link_change_wake_override_r;
   logic flex_filter1_alloc_r;
   logic flex_filter1_wake_en_r;
   logic flex_filter0_alloc_r;
   logic flex_filter0_wake_en_r;
   logic [31:0] wake_filter_control_r;
   logic [31:0] reg_rdata_r;
   logic host_release;
   logic pme_reset;
   logic [wake_pkg::EV_WIDTH-1:0] ev_status;
   logic [wake_pkg::EV_WIDTH-1:0] ev_mask;

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   logic wr_ctl;
   logic wr_filt;
   logic wr_mask;
   logic rd_stat;
   assign wr_ctl = reg_wr && reg_addr == wake_pkg::WAKE_CONTROL_OFF;
   assign wr_filt = reg_wr && reg_addr == wake_pkg::WAKE_FILTER_CONTROL_OFF;
   assign wr_mask = reg_wr && reg_addr == wake_pkg::WAKE_EVENT_MASK_OFF;
   assign rd_stat = reg_rd && reg_addr == wake_pkg::WAKE_EVENT_STATUS_OFF;

   // ---------------------------------------------------------------
   // Wake qualification
   // ---------------------------------------------------------------
   logic link_gate;
   logic link_wake;
   logic magic_wake;
   logic flex0_wake;
   logic flex1_wake;
   logic any_wake;

   // Override bypasses the filter-control link enable
   assign link_gate = link_change_wake_override_r ? 1'b1 :
      wake_filter_control_r[wake_pkg::LINK_CHANGE_FILTER_ENABLE_BIT];
   assign link_wake = link_change && apm_wake_enable_r
      && link_change_wake_enable_r && link_gate;
   assign magic_wake = magic_match && apm_wake_enable_r;
   assign flex0_wake = flex0_match && flex_filter0_alloc_r && flex_filter0_wake_en_r;
   assign flex1_wake = flex1_match && flex_filter1_alloc_r && flex_filter1_wake_en_r;
   assign any_wake = magic_wake || link_wake || flex0_wake || flex1_wake || other_wake_event;

   assign flex0_to_manageability = ~flex_filter0_alloc_r;
   assign flex1_to_manageability = ~flex_filter1_alloc_r;

   // ---------------------------------------------------------------
   // Power-management bits
   // ---------------------------------------------------------------
   host_reset_edge u_edge (
      .mclk(mclk),
      .rst_n(rst_n),
      .host_reset_n(host_reset_n),
      .release_pulse(host_release)
   );

   // These survive the ordinary reset; only power-on, or host release when d3cold_supported is low, clears them
   assign pme_reset = !por_n || (host_release && !d3cold_supported);

   always_ff @(posedge mclk) begin
      if (pme_reset) begin
         pme_en_r <= 1'b0;
      end else if (wr_ctl) begin
         pme_en_r <= reg_wdata[wake_pkg::PME_EN_BIT];
      end else if (cfg_pme_en_wr) begin
         pme_en_r <= cfg_pme_en_wdata;
      end
   end

   // Single flop read by both paths; a wake event wins over a clear
   always_ff @(posedge mclk) begin
      if (pme_reset) begin
         pme_status_r <= 1'b0;
      end else if (any_wake) begin
         pme_status_r <= 1'b1;
      end else if ((wr_ctl && reg_wdata[wake_pkg::PME_STATUS_BIT]) || cfg_pme_status_clr) begin
         pme_status_r <= 1'b0;
      end
   end

   assign pme_en = pme_en_r;
   assign pme_status = pme_status_r;

   // Pin goes low while status is set and either PME or APM assertion is allowed
   always_ff @(posedge mclk) begin
      if (pme_reset) begin
         wake_pin_n <= 1'b1;
      end else begin
         wake_pin_n <= ~(pme_status_r && (pme_en_r || (apm_assert_pme_r && apm_wake_enable_r)));
      end
   end

   // ---------------------------------------------------------------
   // Ordinary control bits
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         apm_wake_enable_r <= nvm_apm_wake_enable;
         link_change_wake_override_r <= nvm_link_change_wake_override;
         apm_assert_pme_r <= 1'b0;
         link_change_wake_enable_r <= 1'b0;
         flex_filter1_alloc_r <= 1'b0;
         flex_filter1_wake_en_r <= 1'b0;
         flex_filter0_alloc_r <= 1'b0;
         flex_filter0_wake_en_r <= 1'b0;
      end else if (wr_ctl) begin
         apm_wake_enable_r <= reg_wdata[wake_pkg::APM_WAKE_ENABLE_BIT];
         apm_assert_pme_r <= reg_wdata[wake_pkg::APM_ASSERT_PME_BIT];
         link_change_wake_enable_r <= reg_wdata[wake_pkg::LINK_CHANGE_WAKE_ENABLE_BIT];
         link_change_wake_override_r <= reg_wdata[wake_pkg::LINK_CHANGE_WAKE_OVERRIDE_BIT];
         flex_filter1_alloc_r <= reg_wdata[wake_pkg::FLEX_FILTER1_ALLOC_BIT];
         flex_filter1_wake_en_r <= reg_wdata[wake_pkg::FLEX_FILTER1_WAKE_EN_BIT];
         flex_filter0_alloc_r <= reg_wdata[wake_pkg::FLEX_FILTER0_ALLOC_BIT];
         flex_filter0_wake_en_r <= reg_wdata[wake_pkg::FLEX_FILTER0_WAKE_EN_BIT];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wake_filter_control_r <= wake_pkg::WAKE_FILTER_CONTROL_RST;
      end else if (wr_filt) begin
         wake_filter_control_r <= reg_wdata;
      end
   end

   // ---------------------------------------------------------------
   // Event status and interrupt
   // ---------------------------------------------------------------
   wake_event_irq u_irq (
      .mclk(mclk),
      .rst_n(rst_n),
      .event_in({flex1_wake, flex0_wake, link_wake, magic_wake}),
      .status_read(rd_stat),
      .mask_write(wr_mask),
      .mask_wdata(reg_wdata[wake_pkg::EV_WIDTH-1:0]),
      .status_r(ev_status),
      .mask_r(ev_mask),
      .irq(irq)
   );

   // ---------------------------------------------------------------
   // Read path, data valid the cycle after the strobe
   // ---------------------------------------------------------------
   logic [31:0] ctl_view;
   always_comb begin
      ctl_view = wake_pkg::READ_ZERO;
      ctl_view[wake_pkg::APM_WAKE_ENABLE_BIT] = apm_wake_enable_r;
      ctl_view[wake_pkg::PME_EN_BIT] = pme_en_r;
      ctl_view[wake_pkg::PME_STATUS_BIT] = pme_status_r;
      ctl_view[wake_pkg::APM_ASSERT_PME_BIT] = apm_assert_pme_r;
      ctl_view[wake_pkg::LINK_CHANGE_WAKE_ENABLE_BIT] = link_change_wake_enable_r;
      ctl_view[wake_pkg::LINK_CHANGE_WAKE_OVERRIDE_BIT] = link_change_wake_override_r;
      ctl_view[wake_pkg::FLEX_FILTER1_ALLOC_BIT] = flex_filter1_alloc_r;
      ctl_view[wake_pkg::FLEX_FILTER1_WAKE_EN_BIT] = flex_filter1_wake_en_r;
      ctl_view[wake_pkg::FLEX_FILTER0_ALLOC_BIT] = flex_filter0_alloc_r;
      ctl_view[wake_pkg::FLEX_FILTER0_WAKE_EN_BIT] = flex_filter0_wake_en_r;
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         reg_rdata_r <= wake_pkg::READ_ZERO;
      end else if (reg_rd) begin
         unique case (reg_addr)
            wake_pkg::WAKE_CONTROL_OFF: reg_rdata_r <= ctl_view;
            wake_pkg::WAKE_FILTER_CONTROL_OFF: reg_rdata_r <= wake_filter_control_r;
            wake_pkg::WAKE_EVENT_STATUS_OFF: reg_rdata_r <= {28'h0000000, ev_status};
            wake_pkg::WAKE_EVENT_MASK_OFF: reg_rdata_r <= {28'h0000000, ev_mask};
            default: reg_rdata_r <= wake_pkg::READ_ZERO;
         endcase
      end else begin
         reg_rdata_r <= wake_pkg::READ_ZERO;
      end
   end

   assign reg_rdata = reg_rdata_r;
endmodule

// *** rtl/wake_event_irq.sv ***
// Sticky event status with clear-on-read, mask and level interrupt
`timescale 1ns/1ps
module wake_event_irq (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Events and software access
   input wire logic [wake_pkg::EV_WIDTH-1:0] event_in,
   input wire logic status_read,
   input wire logic mask_write,
   input wire logic [wake_pkg::EV_WIDTH-1:0] mask_wdata,
   // State out
   output logic [wake_pkg::EV_WIDTH-1:0] status_r,
   output logic [wake_pkg::EV_WIDTH-1:0] mask_r,
   output logic irq
);
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         mask_r <= wake_pkg::EV_MASK_RST;
      end else if (mask_write) begin
         mask_r <= mask_wdata;
      end
   end

   // A new event wins over the clear of the read in the same cycle
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         status_r <= '0;
      end else if (status_read) begin
         status_r <= event_in;
      end else begin
         status_r <= status_r | event_in;
      end
   end

   assign irq = |(status_r & mask_r);
endmodule

// *** shared/wake_pkg.sv ***
// Package with register map, field positions, reset values and timing counts for wake control
package wake_pkg;
   // ---------------------------------------------------------------
   // Register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [15:0] WAKE_CONTROL_OFF = 16'h5800;
   localparam logic [15:0] WAKE_FILTER_CONTROL_OFF = 16'h5808;
   localparam logic [15:0] WAKE_EVENT_STATUS_OFF = 16'h5880;
   localparam logic [15:0] WAKE_EVENT_MASK_OFF = 16'h5884;
   // ---------------------------------------------------------------
   // Wake control and filter control field positions
   // ---------------------------------------------------------------
   localparam int APM_WAKE_ENABLE_BIT = 0;
   localparam int PME_EN_BIT = 1;
   localparam int PME_STATUS_BIT = 2;
   localparam int APM_ASSERT_PME_BIT = 3;
   localparam int LINK_CHANGE_WAKE_ENABLE_BIT = 4;
   localparam int LINK_CHANGE_WAKE_OVERRIDE_BIT = 5;
   localparam int FLEX_FILTER1_ALLOC_BIT = 6;
   localparam int FLEX_FILTER1_WAKE_EN_BIT = 7;
   localparam int FLEX_FILTER0_ALLOC_BIT = 8;
   localparam int FLEX_FILTER0_WAKE_EN_BIT = 9;
   localparam int LINK_CHANGE_FILTER_ENABLE_BIT = 0;
   // ---------------------------------------------------------------
   // Event status / mask layout
   // ---------------------------------------------------------------
   localparam int EV_MAGIC_BIT = 0;
   localparam int EV_LINK_BIT = 1;
   localparam int EV_FLEX0_BIT = 2;
   localparam int EV_FLEX1_BIT = 3;
   localparam int EV_WIDTH = 4;
   // ---------------------------------------------------------------
   // Reset values and timing
   // ---------------------------------------------------------------
   localparam logic [31:0] WAKE_FILTER_CONTROL_RST = 32'h0000_0000;
   localparam logic [EV_WIDTH-1:0] EV_MASK_RST = 4'h0;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;
   localparam int HOST_RESET_SYNC_CYCLES = 1;
endpackage

// *** sim/tb.sv ***
// Self-checking bench for the wake control register bank
`timescale 1ns/1ps
module tb;
   // -----------------------------------
   // Signals
   // -----------------------------------
   localparam logic [15:0] CTL = wake_pkg::WAKE_CONTROL_OFF;
   localparam logic [15:0] FLT = wake_pkg::WAKE_FILTER_CONTROL_OFF;
   localparam logic [15:0] STS = wake_pkg::WAKE_EVENT_STATUS_OFF;
   localparam logic [15:0] MSK = wake_pkg::WAKE_EVENT_MASK_OFF;
   // Entry: expected status, event index, filter bit, control value
   localparam logic [15:0] TAB [12] = '{16'h2011, 16'hA031, 16'hB011, 16'h3001,
      16'h4101, 16'hC301, 16'h4201, 16'h6041, 16'hE0C1, 16'h6081, 16'h0000, 16'h8001};
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic por_n = 1'b0;
   logic host_reset_n = 1'b1;
   logic d3cold = 1'b0;
   logic nvm_apm = 1'b1;
   logic nvm_ovr = 1'b1;
   logic [15:0] reg_addr = 16'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic cfg_wr = 1'b0;
   logic cfg_d = 1'b0;
   logic service = 1'b0;
   logic [4:0] ev = 5'h0;
   logic rd_d = 1'b0;
   logic [31:0] reg_rdata;
   logic [31:0] d;
   logic [63:0] note;
   logic [63:0] note_q[$];
   logic pme_en, pme_status, f0_mng, f1_mng, wake_pin_n, irq, clr;
   wire [5:0] outs = {irq, wake_pin_n, pme_status, pme_en, f1_mng, f0_mng};
   int n_fail = 0;
   int check_count = 0;
   always #4 mclk = ~mclk;
   wake_control DUT (
      .mclk, .rst_n, .por_n, .host_reset_n, .d3cold_supported(d3cold),
      .nvm_apm_wake_enable(nvm_apm), .nvm_link_change_wake_override(nvm_ovr),
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .cfg_pme_en_wr(cfg_wr), .cfg_pme_en_wdata(cfg_d), .cfg_pme_status_clr(clr),
      .pme_en, .pme_status, .magic_match(ev[0]), .link_change(ev[1]),
      .flex0_match(ev[2]), .flex1_match(ev[3]), .other_wake_event(ev[4]),
      .flex0_to_manageability(f0_mng), .flex1_to_manageability(f1_mng),
      .wake_pin_n, .irq
   );
   wake_host_model HOST (.mclk, .rst_n, .service, .wake_pin_n, .cfg_pme_status_clr(clr));
   // -----------------------------------
   // Tasks
   // -----------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [31:0] m);
      note_q.push_back({m, e});
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic pulse(input logic [4:0] v);
      ev <= v;
      @(posedge mclk);
      ev <= 5'h0;
      @(posedge mclk);
   endtask
   // Levels are looked at mid-cycle, once the edge's updates have landed
   task automatic lvl(input string nm, input logic [5:0] m, input logic [5:0] e);
      @(negedge mclk);
      chk(nm, {26'h0, e}, {26'h0, outs & m});
      @(posedge mclk);
   endtask
   task automatic cfg(input logic v);
      cfg_wr <= 1'b1;
      cfg_d <= v;
      @(posedge mclk);
      cfg_wr <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic hrst;
      host_reset_n <= 1'b0;
      @(posedge mclk);
      host_reset_n <= 1'b1;
      repeat (4) @(posedge mclk);
   endtask
   task automatic results;
      if (n_fail == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Read answers are taken off the queue in issue order
   always @(posedge mclk) begin
      if (rd_d) begin
         note = note_q.pop_front();
         chk("rdata", note[31:0], reg_rdata & note[63:32]);
      end
      rd_d <= reg_rd;
   end
   initial begin
      #100000;
      n_fail++;
      results();
   end
   // -----------------------------------
   // Scenarios
   // -----------------------------------
   initial begin
      void'($urandom(32'h3D8D));
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      por_n <= 1'b1;
      rd(CTL, 32'h21, '1);
      lvl("reset", 6'h0F, 6'h03);
      wr(CTL, 32'hFFFF_FFFB);
      wr(16'h5804, '1);
      rd(16'h5804, 32'h0, '1);
      rd(CTL, 32'h3FB, '1);
      lvl("route", 6'h07, 6'h04);
      d = $urandom();
      wr(FLT, d);
      rd(FLT, d, '1);
      d = $urandom();
      wr(MSK, {28'h0, d[3:0]});
      rd(MSK, {28'h0, d[3:0]}, '1);
      foreach (TAB[i]) begin
         wr(FLT, {31'h0, TAB[i][12]});
         wr(CTL, {20'h0, TAB[i][11:0]} | 32'h4);
         pulse(5'h1 << TAB[i][14:13]);
         lvl("wake", 6'h08, {2'b00, TAB[i][15], 3'b000});
      end
      rd(STS, 32'h0, 32'h0);
      wr(MSK, 32'h1);
      wr(CTL, 32'h00D);
      pulse(5'h01);
      lvl("magic", 6'h38, 6'h28);
      rd(CTL, 32'h00D, '1);
      rd(STS, 32'h1, 32'hF);
      rd(STS, 32'h0, 32'hF);
      lvl("irq", 6'h20, 6'h00);
      wr(CTL, 32'h00D);
      lvl("clear", 6'h18, 6'h10);
      cfg(1'b1);
      rd(CTL, 32'h00B, '1);
      wr(CTL, 32'h002);
      pulse(5'h10);
      lvl("pin", 6'h18, 6'h08);
      service <= 1'b1;
      repeat (8) @(posedge mclk);
      service <= 1'b0;
      lvl("serviced", 6'h18, 6'h10);
      rd(CTL, 32'h002, '1);
      pulse(5'h10);
      hrst();
      lvl("host", 6'h0C, 6'h00);
      cfg(1'b1);
      d3cold <= 1'b1;
      pulse(5'h10);
      hrst();
      lvl("host_d3", 6'h0C, 6'h0C);
      nvm_apm <= 1'b0;
      nvm_ovr <= 1'b0;
      d3cold <= 1'b0;
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      rd(CTL, 32'h006, '1);
      por_n <= 1'b0;
      repeat (2) @(posedge mclk);
      por_n <= 1'b1;
      lvl("por", 6'h1C, 6'h10);
      results();
   end
endmodule

// *** sim/wake_control_monitor.sv ***
// Port-level assertions for the wake control register bank
`timescale 1ns/1ps
module wake_control_monitor (
   // Clock and resets
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic por_n,
   input wire logic host_reset_n,
   input wire logic d3cold_supported,
   // Register port
   input wire logic [15:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // PME state and events
   input wire logic cfg_pme_status_clr,
   input wire logic pme_en,
   input wire logic pme_status,
   input wire logic magic_match,
   input wire logic link_change,
   input wire logic flex0_match,
   input wire logic flex1_match,
   input wire logic other_wake_event,
   // Routing and platform
   input wire logic flex0_to_manageability,
   input wire logic flex1_to_manageability,
   input wire logic wake_pin_n
);
   localparam logic [15:0] CTL = wake_pkg::WAKE_CONTROL_OFF;
   wire ev = magic_match | link_change | flex0_match | flex1_match | other_wake_event;
   wire ctl_rd = reg_rd && reg_addr == CTL;
   wire ctl_wr = reg_wr && reg_addr == CTL;
   // Host release clears the PME bits and lifts the pin when cold power-off is absent
   logic host_prev_r;
   always_ff @(posedge mclk) begin
      host_prev_r <= host_reset_n;
   end
   wire pm_clr = host_reset_n & ~host_prev_r & ~d3cold_supported;
   // -----------------------------------
   // Checks
   // -----------------------------------
   // Power-on reset owns the PME bits, so it silences the checks as well
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!rst_n || !por_n);
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data not zero outside an answer");
   a_en_mirror: assert property ($past(ctl_rd) |-> reg_rdata[1] == $past(pme_en))
      else $error("control read disagrees with pme_en");
   a_status_mirror: assert property ($past(ctl_rd) |-> reg_rdata[2] == $past(pme_status))
      else $error("control read disagrees with pme_status");
   a_flex_route: assert property ($past(ctl_rd) |-> reg_rdata[8] != $past(flex0_to_manageability)
      && reg_rdata[6] != $past(flex1_to_manageability))
      else $error("filter routing disagrees with allocation bits");
   a_write_clear: assert property (ctl_wr && reg_wdata[2] && !ev |=> !pme_status)
      else $error("write of one did not clear pme_status");
   a_cfg_clear: assert property (cfg_pme_status_clr && !ev |=> !pme_status)
      else $error("config clear did not clear pme_status");
   a_status_cause: assert property ($rose(pme_status) |-> $past(ev))
      else $error("pme_status rose without an event");
   a_pin_cause: assert property (!wake_pin_n |-> $past(pme_status))
      else $error("wake pin low without pme_status");
   a_pin_low: assert property (pme_status && pme_en && !pm_clr |=> !wake_pin_n)
      else $error("wake pin not asserted");
   c_magic: cover property (magic_match ##1 pme_status);
   c_pin: cover property ($fell(wake_pin_n));
   c_cfg_clear: cover property (cfg_pme_status_clr ##1 !pme_status);
endmodule
bind wake_control wake_control_monitor mon (
   .mclk, .rst_n, .por_n, .host_reset_n, .d3cold_supported,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .cfg_pme_status_clr, .pme_en, .pme_status, .magic_match, .link_change,
   .flex0_match, .flex1_match, .other_wake_event, .flex0_to_manageability,
   .flex1_to_manageability, .wake_pin_n
);

// *** sim/wake_host_model.sv ***
// Platform model: answers a wake request by clearing PME status via config space
`timescale 1ns/1ps
module wake_host_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Wake handshake
   input wire logic service,
   input wire logic wake_pin_n,
   output logic cfg_pme_status_clr
);
   logic [2:0] low_cnt_r;
   // Slow on purpose: the pin has to stay low until software gets round to it
   always_ff @(posedge mclk) begin
      if (!rst_n || !service || wake_pin_n) begin
         low_cnt_r <= 3'h0;
         cfg_pme_status_clr <= 1'b0;
      end else begin
         low_cnt_r <= low_cnt_r + 3'h1;
         cfg_pme_status_clr <= (low_cnt_r == 3'h3);
      end
   end
endmodule
